/* File: verilog/ulms_pkg.sv */
// shared constants for the line and modem status register block
`default_nettype none
package ulms_pkg;
  localparam logic [2:0] OFF_FLOW_ONE    = 3'h4;
  localparam logic [2:0] OFF_LINE_STATUS = 3'h5;
  localparam logic [2:0] OFF_FLOW_TWO    = 3'h5;
  localparam logic [2:0] OFF_MODEM_STAT  = 3'h6;
  localparam logic [7:0] LCR_ENH_KEY     = 8'hbf;
  localparam logic [7:0] LSR_RESET       = 8'h60;
  localparam logic [7:0] MSR_RESET       = 8'h00;
  localparam logic [7:0] FLOW_RESET      = 8'h00;
  localparam int LCR_DLAB_BIT    = 7;
  localparam int SFR_SEL_BIT     = 2;
  localparam int MCR_DTR_BIT     = 0;
  localparam int MCR_RTS_BIT     = 1;
  localparam int MCR_OP1_BIT     = 2;
  localparam int MCR_OP2_BIT     = 3;
  localparam int MCR_LOOP_BIT    = 4;
  localparam int LSR_DR          = 0;
  localparam int LSR_OE          = 1;
  localparam int LSR_PE          = 2;
  localparam int LSR_FE          = 3;
  localparam int LSR_BI          = 4;
  localparam int LSR_THRE        = 5;
  localparam int LSR_TEMT        = 6;
  localparam int LSR_FIFO_ERR    = 7;
  // input index order inside the modem block: cts, dsr, ri, cd
  localparam int MI_CTS          = 0;
  localparam int MI_DSR          = 1;
  localparam int MI_RI           = 2;
  localparam int MI_CD           = 3;
endpackage
`default_nettype wire

/* File: verilog/ulms_sync2.sv */
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module ulms_sync2 (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic meta_reg;

  // pins idle high (inactive) so reset to one avoids a false change flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_reg  <= 1'b1;
      level_out <= 1'b1;
    end else begin
      meta_reg  <= pin_in;
      level_out <= meta_reg;
    end
  end
endmodule // ulms_sync2
`default_nettype wire

/* File: verilog/ulms_modem_flag.sv */
// one modem input: status bit and sticky change flag
`timescale 1ns/1ps
`default_nettype none
module ulms_modem_flag (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic level_n,
  input  wire logic loop_level,
  input  wire logic loop_en,
  input  wire logic rise_only,
  input  wire logic clear,
  output var  logic status,
  output var  logic delta
);
  logic cur;
  logic prev_reg;
  logic changed;

  // loopback drives the status bit from the control register instead of the pin
  assign cur     = loop_en ? loop_level : ~level_n;
  // ring flag: status goes 1->0 means the low-active pin went low to high
  assign changed = rise_only ? (prev_reg & ~cur) : (prev_reg ^ cur);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_reg <= 1'b0;
      status   <= 1'b0;
    end else begin
      prev_reg <= cur;
      status   <= cur;
    end
  end

  // a change in the read cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      delta <= 1'b0;
    end else if (changed) begin
      delta <= 1'b1;
    end else if (clear) begin
      delta <= 1'b0;
    end
  end
endmodule // ulms_modem_flag
`default_nettype wire

/* File: verilog/ulms_status_regs.sv */
// line status, modem status and flow-control on-character registers
//
// Behaviour
// - on-chars reachable at line_control 0xbf, sfr bit2 zero
// - on-chars cleared only by power-on reset
// - line status at 05 when dlab clear, reset 60
// - bit7 set while any fifo byte errored
// - bit6 set when transmitter fully idle
// - bit5 set when holding register empties
// - bit4 flags break on head byte
// - bit3 flags framing error on head byte
// - bit2 flags parity error on head byte
// - bit1 set on arrival into full fifo
// - bit0 set while receive fifo holds data
// - modem status at 06 under three zero gates
// - status bits 7..4 are inverted cd ri dsr cts
// - loopback maps control bits 3,2,0,1 to 7..4
// - delta cd dsr cts on any change
// - delta ri only on low-to-high pin change
// - any delta with enable raises modem interrupt
// - control bit4 enables internal loopback
// - control bit2 selects alternate registers at 6,7 while control bit4 is clear
// - dlab hides line and modem status
`timescale 1ns/1ps
`default_nettype none
module ulms_status_regs (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       por_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] line_control,
  input  wire logic [7:0] modem_control,
  input  wire logic [7:0] special_function_reg,
  input  wire logic       modem_int_en,
  input  wire logic       rx_fifo_nonempty,
  input  wire logic       rx_fifo_full,
  input  wire logic       rx_char_arrive,
  input  wire logic       rx_fifo_any_error,
  input  wire logic       head_parity_err,
  input  wire logic       head_framing_err,
  input  wire logic       head_break,
  input  wire logic       thr_empty,
  input  wire logic       tsr_empty,
  input  wire logic       thr_to_tsr,
  input  wire logic       carrier_detect_n,
  input  wire logic       ring_indicator_n,
  input  wire logic       dsr_n,
  input  wire logic       cts_n,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rvalid,
  output var  logic       modem_int,
  output var  logic       loopback_en,
  output var  logic       alt_regs_sel,
  output var  logic [7:0] flow_on_char_one,
  output var  logic [7:0] flow_on_char_two
);
  // ==========================================================
  // access decode
  logic       enh_access;
  logic       std_access;
  logic       msr_access;
  logic       rd_lsr;
  logic       rd_msr;
  logic [7:0] line_status;
  logic [7:0] modem_input_status;
  logic [3:0] pin_sync;
  logic [3:0] pin_raw;
  logic [3:0] loop_lvl;
  logic [3:0] mstat;
  logic [3:0] mdelta;
  logic       overrun_reg;
  logic       thre_reg;
  logic       temt_reg;
  logic       clr_delta;
  logic [7:0] rdata_next;

  assign enh_access = (line_control == ulms_pkg::LCR_ENH_KEY)
                      && !special_function_reg[ulms_pkg::SFR_SEL_BIT];
  assign std_access = !line_control[ulms_pkg::LCR_DLAB_BIT];
  assign msr_access = std_access && !modem_control[ulms_pkg::MCR_OP1_BIT]
                      && !special_function_reg[ulms_pkg::SFR_SEL_BIT];
  assign rd_lsr = reg_rd && std_access && (reg_addr == ulms_pkg::OFF_LINE_STATUS);
  assign rd_msr = reg_rd && msr_access && (reg_addr == ulms_pkg::OFF_MODEM_STAT);

  // ==========================================================
  // flow-control on-characters: power-on reset only
  always_ff @(posedge clk) begin
    if (!por_n) begin
      flow_on_char_one <= ulms_pkg::FLOW_RESET;
      flow_on_char_two <= ulms_pkg::FLOW_RESET;
    end else if (reg_wr && enh_access) begin
      if (reg_addr == ulms_pkg::OFF_FLOW_ONE) begin
        flow_on_char_one <= reg_wdata;
      end
      if (reg_addr == ulms_pkg::OFF_FLOW_TWO) begin
        flow_on_char_two <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // line status
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overrun_reg <= ulms_pkg::LSR_RESET[ulms_pkg::LSR_OE];
    end else if (rx_char_arrive && rx_fifo_full) begin
      overrun_reg <= 1'b1;
    end else if (rd_lsr) begin
      overrun_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thre_reg <= ulms_pkg::LSR_RESET[ulms_pkg::LSR_THRE];
      temt_reg <= ulms_pkg::LSR_RESET[ulms_pkg::LSR_TEMT];
    end else begin
      if (thr_to_tsr) begin
        thre_reg <= 1'b1;
      end else if (!thr_empty) begin
        thre_reg <= 1'b0;
      end
      temt_reg <= thr_empty && tsr_empty && !thr_to_tsr;
    end
  end

  always_comb begin
    line_status = 8'h00;
    line_status[ulms_pkg::LSR_FIFO_ERR] = rx_fifo_any_error;
    line_status[ulms_pkg::LSR_TEMT]     = temt_reg;
    line_status[ulms_pkg::LSR_THRE]     = thre_reg;
    line_status[ulms_pkg::LSR_BI]       = rx_fifo_nonempty && head_break;
    line_status[ulms_pkg::LSR_FE]       = rx_fifo_nonempty && head_framing_err;
    line_status[ulms_pkg::LSR_PE]       = rx_fifo_nonempty && head_parity_err;
    line_status[ulms_pkg::LSR_OE]       = overrun_reg;
    line_status[ulms_pkg::LSR_DR]       = rx_fifo_nonempty;
  end

  // ==========================================================
  // modem inputs
  assign pin_raw = {carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
  assign loop_lvl = {modem_control[ulms_pkg::MCR_OP2_BIT],
                     modem_control[ulms_pkg::MCR_OP1_BIT],
                     modem_control[ulms_pkg::MCR_DTR_BIT],
                     modem_control[ulms_pkg::MCR_RTS_BIT]};
  assign clr_delta = rd_msr;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_modem
      ulms_sync2 u_sync (
        .clk       (clk),
        .reset_n   (reset_n),
        .pin_in    (pin_raw[gi]),
        .level_out (pin_sync[gi])
      );
      ulms_modem_flag u_flag (
        .clk        (clk),
        .reset_n    (reset_n),
        .level_n    (pin_sync[gi]),
        .loop_level (loop_lvl[gi]),
        .loop_en    (loopback_en),
        .rise_only  (gi == ulms_pkg::MI_RI),
        .clear      (clr_delta),
        .status     (mstat[gi]),
        .delta      (mdelta[gi])
      );
    end
  endgenerate

  assign modem_input_status = {mstat, mdelta};

  // ==========================================================
  // control outputs and read port
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      loopback_en  <= 1'b0;
      alt_regs_sel <= 1'b0;
      modem_int    <= 1'b0;
    end else begin
      loopback_en  <= modem_control[ulms_pkg::MCR_LOOP_BIT];
      alt_regs_sel <= !modem_control[ulms_pkg::MCR_LOOP_BIT]
                      && modem_control[ulms_pkg::MCR_OP1_BIT];
      modem_int    <= modem_int_en && (|mdelta);
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (enh_access && reg_addr == ulms_pkg::OFF_FLOW_ONE) begin
      rdata_next = flow_on_char_one;
    end else if (enh_access && reg_addr == ulms_pkg::OFF_FLOW_TWO) begin
      rdata_next = flow_on_char_two;
    end else if (std_access && reg_addr == ulms_pkg::OFF_LINE_STATUS) begin
      rdata_next = line_status;
    end else if (msr_access && reg_addr == ulms_pkg::OFF_MODEM_STAT) begin
      rdata_next = modem_input_status;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end
endmodule // ulms_status_regs
`default_nettype wire

/* File: tb/ulms_modem_model.sv */
// partner model: modem pins, active low, driven from asserted levels
`timescale 1ns/1ps
`default_nettype none
module ulms_modem_model (
  input  wire logic [3:0] want,
  output wire logic       cts_n,
  output wire logic       dsr_n,
  output wire logic       ring_indicator_n,
  output wire logic       carrier_detect_n
);
  // skew keeps pin edges away from the clock edge
  assign #3 {carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = ~want;
endmodule // ulms_modem_model
`default_nettype wire

/* File: tb/ulms_status_regs_properties.sv */
// port assertions for the status register block
`timescale 1ns/1ps
`default_nettype none
module ulms_status_regs_properties (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       por_n,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] line_control,
  input wire logic [7:0] modem_control,
  input wire logic [7:0] special_function_reg,
  input wire logic       rx_fifo_nonempty,
  input wire logic       rx_fifo_any_error,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       loopback_en,
  input wire logic [7:0] flow_on_char_one
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // the second on-char shares offset 5 with line status, so the key decode comes first
  wire logic key = line_control == 8'hbf && !special_function_reg[2];
  wire logic ls = reg_rd && reg_addr == 3'h5 && !line_control[7];
  wire logic ms = reg_rd && reg_addr == 3'h6
    && !(line_control[7] | modem_control[2] | special_function_reg[2]);
  a_read_answer:
    assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  a_answer_cause:
    assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray answer");
  a_dlab_hides:
    assert property (reg_rd && line_control[7] && !key |=> !reg_rdata) else $error("hidden");
  a_ready_bit:
    assert property (ls |=> reg_rdata[0] == $past(rx_fifo_nonempty)) else $error("ready");
  a_error_sum:
    assert property (ls |=> reg_rdata[7] == $past(rx_fifo_any_error)) else $error("err sum");
  a_loop_map:
    assert property (ms && loopback_en |=> reg_rdata[7] == $past(modem_control[3])
      && reg_rdata[5:4] == {$past(modem_control[0]), $past(modem_control[1])})
      else $error("loop map");
  a_flow_read:
    assert property (reg_rd && reg_addr == 3'h4 && key |=> reg_rdata == flow_on_char_one)
      else $error("on-char read");
  a_flow_keep:
    assert property (@(posedge clk) disable iff (!por_n)
      !reg_wr |=> $stable(flow_on_char_one)) else $error("on-char lost");
endmodule // ulms_status_regs_properties
bind ulms_status_regs ulms_status_regs_properties i_props (.*);
`default_nettype wire

/* File: tb/test_ulms_status_regs.sv */
// self-checking bench for the line and modem status register block
`timescale 1ns/1ps
`default_nettype none
module test_ulms_status_regs;
  logic       clk, reset_n, por_n, reg_rd, reg_wr, modem_int_en, rx_char_arrive;
  logic       rx_fifo_nonempty, rx_fifo_full, rx_fifo_any_error, thr_to_tsr;
  logic       head_parity_err, head_framing_err, head_break, thr_empty, tsr_empty;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, line_control, modem_control, special_function_reg;
  logic [3:0] want, prev, d;
  wire logic  carrier_detect_n, ring_indicator_n, dsr_n, cts_n;
  wire logic  reg_rvalid, modem_int, loopback_en, alt_regs_sel;
  wire logic [7:0] reg_rdata, flow_on_char_one, flow_on_char_two;
  int         fails, tests_run, cyc;
  ulms_status_regs i_ulms_status_regs (.*);
  ulms_modem_model i_ulms_modem_model (.*);
  task automatic chk(logic [7:0] g, logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    @(negedge clk) reg_addr = a;
    reg_rd = 1;
    @(negedge clk) reg_rd = 0;
    chk(reg_rdata & m, e);
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] v);
    @(negedge clk) reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clk) reg_wr = 0;
  endtask
  task automatic finish_test;
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      finish_test();
    end
  end
  // ==========================================
  // stimulus
  initial begin
    {reset_n, por_n, reg_rd, reg_wr, modem_int_en, rx_char_arrive, thr_to_tsr} = '0;
    {rx_fifo_nonempty, rx_fifo_full, rx_fifo_any_error, head_break} = '0;
    {head_parity_err, head_framing_err, reg_addr, reg_wdata, want} = '0;
    {line_control, modem_control, special_function_reg} = '0;
    {thr_empty, tsr_empty} = 2'b11;
    repeat (6) @(negedge clk);
    {reset_n, por_n} = 2'b11;
    rd(5, 8'h60);
    rd(6, 8'h00);
    line_control = 8'hbf;
    wr(4, 8'ha5);
    wr(5, 8'h3c);
    rd(4, 8'ha5);
    special_function_reg = 8'h04;
    rd(4, 8'h00);
    special_function_reg = 8'h00;
    reset_n = 0;
    @(negedge clk) reset_n = 1;
    rd(5, 8'h3c);
    line_control = 8'h80;
    rd(5, 8'h00);
    rd(6, 8'h00);
    line_control = 8'h00;
    {rx_fifo_nonempty, rx_fifo_any_error} = 2'b11;
    for (int i = 2; i < 5; i++) begin
      {head_break, head_framing_err, head_parity_err} = 3'b001 << (i - 2);
      rd(5, 8'he1 | (8'h01 << i));
    end
    {rx_fifo_nonempty, rx_fifo_any_error, head_break} = 3'b000;
    rd(5, 8'h60);
    {rx_fifo_nonempty, rx_fifo_full, rx_char_arrive} = 3'b111;
    @(negedge clk) rx_char_arrive = 0;
    rd(5, 8'h63);
    rd(5, 8'h61);
    {thr_empty, tsr_empty} = 2'b00;
    rd(5, 8'h01);
    {thr_empty, thr_to_tsr} = 2'b11;
    @(negedge clk) thr_to_tsr = 0;
    rd(5, 8'h21);
    tsr_empty = 1;
    repeat (2) @(negedge clk);
    rd(5, 8'h61);
    modem_int_en = 1;
    // ring delta only when its pin returns high
    for (int i = 0; i < 5; i++) begin
      prev = want;
      want = 4'b0001 << i;
      d = prev ^ want;
      d[2] = d[2] & prev[2];
      repeat (5) @(negedge clk);
      chk({7'h00, modem_int}, {7'h00, |d});
      rd(6, {want, d});
    end
    rd(6, 8'h00);
    modem_control = 8'h1b;
    repeat (4) @(negedge clk);
    rd(6, 8'hb0, 8'hf0);
    rd(6, 8'hb0);
    chk({7'h00, loopback_en}, 8'h01);
    modem_control = 8'h04;
    repeat (2) @(negedge clk);
    chk({7'h00, alt_regs_sel}, 8'h01);
    rd(6, 8'h00);
    finish_test();
  end
endmodule // test_ulms_status_regs
`default_nettype wire
